// *** design/pif_pkg.sv ***
// =====================================================================
// Shared constants for the peripheral interrupt flag block.
package pif_pkg;
  // =====================================================================
  // Register byte offsets on the APB.
  localparam logic [7:0] OFF_FLAG     = 8'h00;
  localparam logic [7:0] OFF_ENABLE   = 8'h04;
  localparam logic [7:0] OFF_RCAUSE   = 8'h08;
  localparam logic [7:0] OFF_T2CTL    = 8'h0c;
  localparam logic [7:0] OFF_IRQCTL   = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_MASK     = 8'h18;

  // =====================================================================
  // Flag and enable bit positions, shared by both registers.
  localparam int BIT_ADC  = 6;
  localparam int BIT_RX   = 5;
  localparam int BIT_TX   = 4;
  localparam int BIT_SSP  = 3;
  localparam int BIT_CCP  = 2;
  localparam int BIT_T2   = 1;
  localparam int BIT_T1   = 0;
  localparam int NSRC     = 7;
  // Bits that latch and wait for software; the others mirror a level.
  localparam logic [6:0] STICKY_MASK = 7'h4f;

  // =====================================================================
  // Reset-cause register layout and reset value.
  localparam int BIT_PRIO = 7;
  localparam int BIT_RI   = 4;
  localparam int BIT_TO   = 3;
  localparam int BIT_PD   = 2;
  localparam int BIT_POR  = 1;
  localparam int BIT_BOR  = 0;
  localparam logic [7:0] RCAUSE_RST = 8'h1c;

  // =====================================================================
  // Interrupt control register layout.
  localparam int BIT_GIE  = 1;
  localparam int BIT_PGE  = 0;

  // =====================================================================
  // Capture/compare unit modes.
  typedef enum logic [1:0] {
    PIF_CCP_OFF     = 2'b00,
    PIF_CCP_CAPTURE = 2'b01,
    PIF_CCP_COMPARE = 2'b10,
    PIF_CCP_PWM     = 2'b11
  } pif_ccp_mode_t;
endpackage

// *** design/pif_postscale.sv ***
`timescale 1ns/1ps
// =====================================================================
// Four-bit postscaler: one pulse every sel+1 timer 2 period matches.
module pif_postscale (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Match input and divide select.
  input  wire logic       match,
  input  wire logic [3:0] sel,
  // Divided pulse.
  output logic            pulse_r
);
  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic       pulse_nxt;
  wire        hit = match && (count_r >= sel);

  // The counter wraps on hit, so sel 0 gives 1:1 and sel 15 gives 1:16.
  assign count_nxt = hit ? 4'h0 : (match ? count_r + 4'h1 : count_r);
  assign pulse_nxt = hit;

  // Counter and pulse registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 4'h0;
      pulse_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  property p_ps_wrap;
    @(posedge pclk) disable iff (!presetn)
      (match && count_r == sel) |=> (pulse_r && count_r == 4'h0);
  endproperty
  a_ps_wrap: assert property (p_ps_wrap) else $error("postscaler did not wrap on select");
endmodule

// *** design/pif_flag_bit.sv ***
`timescale 1ns/1ps
// =====================================================================
// One software-cleared flag; a set event wins over a clearing write.
module pif_flag_bit (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Hardware event and software write.
  input  wire logic set_evt,
  input  wire logic wr_en,
  input  wire logic wr_val,
  // Flag state.
  output logic      q_r
);
  logic q_nxt;

  // The event is taken regardless of any enable bit.
  assign q_nxt = set_evt | (wr_en ? wr_val : q_r);

  // Flag register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

// *** design/pif_top.sv ***
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Flags set on their event regardless of any enable bit.
// - Without priority levels, group enable must also be set for any periph_irq request.
// - Receive flag, bit 5, read-only, mirrors full receive buffer.
// - Transmit flag, bit 4, read-only, mirrors empty transmit buffer.
// - Sync serial flag, bit 3, sets on transfer done, held until cleared.
// - Capcmp flag, bit 2, sets on capture or compare; idle in PWM.
// - Timer 2 flag, bit 1, set by postscaler output; software clears it.
// - Timer 1 flag, bit 0, sets on 16-bit rollover; software clears it.
// - Enable bits share flag positions 6..0; one enables, zero disables.
// - Bit 7 of flag and enable registers reads zero.
// - Postscaler is four bits with ratios 1:1 to 1:16.
// - Priority bit 7 of reset-cause selects two levels or single level.
// - Reset-cause holds instruction, watchdog, power-down, power-on, brown-out bits.
module pif_top (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral events and levels.
  input  wire logic        adc_done,
  input  wire logic        rx_buf_full,
  input  wire logic        tx_buf_empty,
  input  wire logic        ssp_done,
  input  wire logic        ccp_capture,
  input  wire logic        ccp_compare,
  input  wire logic [1:0]  ccp_mode,
  input  wire logic        t2_period_match,
  input  wire logic        t1_rollover,
  // Reset-cause events.
  input  wire logic        reset_instr_evt,
  input  wire logic        wdt_timeout_evt,
  input  wire logic        sleep_evt,
  input  wire logic        wdt_clear_evt,
  input  wire logic        por_evt,
  input  wire logic        bor_evt,
  // Interrupt requests.
  output logic             periph_irq,
  output logic             irq
);
  // =====================================================================
  // APB decode.
  wire setup_w  = psel && !penable && !pready;
  wire wr_w     = setup_w && pwrite;
  wire rd_w     = setup_w && !pwrite;
  wire sel_flag = paddr == pif_pkg::OFF_FLAG;
  wire sel_en   = paddr == pif_pkg::OFF_ENABLE;
  wire sel_rc   = paddr == pif_pkg::OFF_RCAUSE;
  wire sel_t2   = paddr == pif_pkg::OFF_T2CTL;
  wire sel_ic   = paddr == pif_pkg::OFF_IRQCTL;
  wire sel_st   = paddr == pif_pkg::OFF_STATUS;
  wire sel_mk   = paddr == pif_pkg::OFF_MASK;
  wire mapped   = sel_flag | sel_en | sel_rc | sel_t2 | sel_ic | sel_st | sel_mk;
  wire wr_flag  = wr_w && sel_flag;
  wire wr_en    = wr_w && sel_en;
  wire wr_rc    = wr_w && sel_rc;
  wire wr_t2    = wr_w && sel_t2;
  wire wr_ic    = wr_w && sel_ic;
  wire wr_st    = wr_w && sel_st;
  wire wr_mk    = wr_w && sel_mk;

  // =====================================================================
  // State registers.
  logic [6:0] enable_r;
  logic [6:0] enable_nxt;
  logic [7:0] rcause_r;
  logic [7:0] rcause_nxt;
  logic [3:0] t2sel_r;
  logic [3:0] t2sel_nxt;
  logic [1:0] irqctl_r;
  logic [1:0] irqctl_nxt;
  logic [6:0] status_r;
  logic [6:0] status_nxt;
  logic [6:0] mask_r;
  logic [6:0] mask_nxt;
  logic       rx_prev_r;
  logic       tx_prev_r;
  logic       irq_nxt;
  logic       pirq_nxt;
  logic [31:0] rdata_nxt;

  // =====================================================================
  // Event sources.
  logic       ps_pulse;
  wire        ccp_evt = (ccp_mode == pif_pkg::PIF_CCP_CAPTURE && ccp_capture) ||
                        (ccp_mode == pif_pkg::PIF_CCP_COMPARE && ccp_compare);
  wire [6:0]  evt_w   = {adc_done, rx_buf_full && !rx_prev_r, tx_buf_empty && !tx_prev_r,
                         ssp_done, ccp_evt, ps_pulse, t1_rollover};
  logic [6:0] flag_w;

  // Timer 2 postscaler driven by period matches.
  pif_postscale u_ps (
    .pclk    (pclk),
    .presetn (presetn),
    .match   (t2_period_match),
    .sel     (t2sel_r),
    .pulse_r (ps_pulse)
  );

  // Sticky flags latch; the serial buffer flags follow their buffer levels.
  genvar gi;
  generate
    for (gi = 0; gi < pif_pkg::NSRC; gi++) begin : g_flag
      if (pif_pkg::STICKY_MASK[gi]) begin : g_sticky
        pif_flag_bit u_bit (
          .pclk    (pclk),
          .presetn (presetn),
          .set_evt (evt_w[gi]),
          .wr_en   (wr_flag),
          .wr_val  (pwdata[gi]),
          .q_r     (flag_w[gi])
        );
      end else if (gi == pif_pkg::BIT_RX) begin : g_rx
        assign flag_w[gi] = rx_buf_full;
      end else begin : g_tx
        assign flag_w[gi] = tx_buf_empty;
      end
    end
  endgenerate

  // =====================================================================
  // Register next values.
  assign enable_nxt = wr_en ? pwdata[6:0] : enable_r;
  assign t2sel_nxt  = wr_t2 ? pwdata[3:0] : t2sel_r;
  assign irqctl_nxt = wr_ic ? pwdata[1:0] : irqctl_r;
  assign mask_nxt   = wr_mk ? pwdata[6:0] : mask_r;
  // Write one clears a status bit; a new event in the same cycle wins.
  assign status_nxt = evt_w | (status_r & ~(wr_st ? pwdata[6:0] : 7'h00));

  // Reset-cause bits: hardware events override software writes.
  always_comb begin
    rcause_nxt = rcause_r;
    if (wr_rc) begin
      rcause_nxt[pif_pkg::BIT_PRIO] = pwdata[pif_pkg::BIT_PRIO];
      rcause_nxt[pif_pkg::BIT_RI]   = pwdata[pif_pkg::BIT_RI];
      rcause_nxt[pif_pkg::BIT_POR]  = pwdata[pif_pkg::BIT_POR];
      rcause_nxt[pif_pkg::BIT_BOR]  = pwdata[pif_pkg::BIT_BOR];
    end
    if (wdt_clear_evt) begin
      rcause_nxt[pif_pkg::BIT_TO] = 1'b1;
      rcause_nxt[pif_pkg::BIT_PD] = 1'b1;
    end
    if (reset_instr_evt) begin
      rcause_nxt[pif_pkg::BIT_RI] = 1'b0;
    end
    if (wdt_timeout_evt) begin
      rcause_nxt[pif_pkg::BIT_TO] = 1'b0;
    end
    if (sleep_evt) begin
      rcause_nxt[pif_pkg::BIT_PD] = 1'b0;
    end
    if (por_evt) begin
      rcause_nxt[pif_pkg::BIT_POR] = 1'b0;
    end
    if (bor_evt) begin
      rcause_nxt[pif_pkg::BIT_BOR] = 1'b0;
    end
  end

  // =====================================================================
  // Interrupt request gating.
  wire prio_on  = rcause_r[pif_pkg::BIT_PRIO];
  wire global_irq_enable      = irqctl_r[pif_pkg::BIT_GIE];
  wire pge      = irqctl_r[pif_pkg::BIT_PGE];
  wire any_req  = |(flag_w & enable_r);
  // Single level needs both global and group enables; two levels let either one pass.
  assign pirq_nxt = any_req && (prio_on ? (global_irq_enable || pge) : (global_irq_enable && pge));
  assign irq_nxt  = |(status_r & mask_r);

  // =====================================================================
  // Read data; unused high bits and bit 7 of flag and enable read zero.
  assign rdata_nxt = sel_flag ? {25'h0, flag_w}       :
                     sel_en   ? {25'h0, enable_r}     :
                     sel_rc   ? {24'h0, rcause_r}     :
                     sel_t2   ? {28'h0, t2sel_r}      :
                     sel_ic   ? {30'h0, irqctl_r}     :
                     sel_st   ? {25'h0, status_r}     :
                     sel_mk   ? {25'h0, mask_r}       : 32'h0;

  // APB answer: ready in the first access cycle, error on unmapped address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w && !mapped;
      prdata  <= rd_w ? rdata_nxt : 32'h0;
    end
  end

  // Control and status registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r  <= 7'h00;
      rcause_r  <= pif_pkg::RCAUSE_RST;
      t2sel_r   <= 4'h0;
      irqctl_r  <= 2'h0;
      status_r  <= 7'h00;
      mask_r    <= 7'h00;
      rx_prev_r <= 1'b0;
      tx_prev_r <= 1'b1; // Matches the empty buffer after reset, so no false edge.
    end else begin
      enable_r  <= enable_nxt;
      rcause_r  <= rcause_nxt;
      t2sel_r   <= t2sel_nxt;
      irqctl_r  <= irqctl_nxt;
      status_r  <= status_nxt;
      mask_r    <= mask_nxt;
      rx_prev_r <= rx_buf_full;
      tx_prev_r <= tx_buf_empty;
    end
  end

  // Interrupt outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq <= 1'b0;
      irq        <= 1'b0;
    end else begin
      periph_irq <= pirq_nxt;
      irq        <= irq_nxt;
    end
  end

  // =====================================================================
  // Assertions.
  sequence s_setup;
    psel && !penable && !pready;
  endsequence

  sequence s_answer;
    ##1 pready;
  endsequence

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
      s_setup |-> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer not in first access cycle");

  property p_adc_set;
    @(posedge pclk) disable iff (!presetn)
      adc_done |=> flag_w[pif_pkg::BIT_ADC];
  endproperty
  a_adc_set: assert property (p_adc_set) else $error("converter flag did not set");

  property p_rx_mirror;
    @(posedge pclk) disable iff (!presetn)
      s_setup ##1 (pready && $past(sel_flag) && !$past(pwrite)) |->
        prdata[pif_pkg::BIT_RX] == $past(rx_buf_full);
  endproperty
  a_rx_mirror: assert property (p_rx_mirror) else $error("receive flag read wrong");

  property p_tx_mirror;
    @(posedge pclk) disable iff (!presetn)
      s_setup ##1 (pready && $past(sel_flag) && !$past(pwrite)) |->
        prdata[pif_pkg::BIT_TX] == $past(tx_buf_empty);
  endproperty
  a_tx_mirror: assert property (p_tx_mirror) else $error("transmit flag read wrong");

  property p_ssp_hold;
    @(posedge pclk) disable iff (!presetn)
      (flag_w[pif_pkg::BIT_SSP] && !wr_flag) |=> flag_w[pif_pkg::BIT_SSP];
  endproperty
  a_ssp_hold: assert property (p_ssp_hold) else $error("sync serial flag lost");

  property p_ccp_pwm;
    @(posedge pclk) disable iff (!presetn)
      (ccp_mode == pif_pkg::PIF_CCP_PWM && !wr_flag && !flag_w[pif_pkg::BIT_CCP]) |=>
        !flag_w[pif_pkg::BIT_CCP];
  endproperty
  a_ccp_pwm: assert property (p_ccp_pwm) else $error("capcmp flag set in PWM mode");

  property p_t2_set;
    @(posedge pclk) disable iff (!presetn)
      ps_pulse |=> flag_w[pif_pkg::BIT_T2];
  endproperty
  a_t2_set: assert property (p_t2_set) else $error("timer 2 flag did not set");

  property p_t1_set;
    @(posedge pclk) disable iff (!presetn)
      (t1_rollover && wr_flag) |=> flag_w[pif_pkg::BIT_T1];
  endproperty
  a_t1_set: assert property (p_t1_set) else $error("timer 1 set lost to clear");

  property p_bit7_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd_w && (sel_flag || sel_en)) |=> prdata[7] == 1'b0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) else $error("bit 7 read as one");

  property p_group_gate;
    @(posedge pclk) disable iff (!presetn)
      (!prio_on && !pge) |=> !periph_irq;
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("request passed without group enable");

  property p_req_raise;
    @(posedge pclk) disable iff (!presetn)
      (any_req && global_irq_enable && pge) |=> periph_irq;
  endproperty
  a_req_raise: assert property (p_req_raise) else $error("request not raised");

  property p_ri_clear;
    @(posedge pclk) disable iff (!presetn)
      reset_instr_evt |=> !rcause_r[pif_pkg::BIT_RI];
  endproperty
  a_ri_clear: assert property (p_ri_clear) else $error("reset instruction bit not cleared");
endmodule

// *** testbench/pif_periph_model.sv ***
`timescale 1ns/1ps
// ==========
// Peripheral side: turns bench requests into event pulses and serial buffer levels.
module pif_periph_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Requests from the bench.
  input  wire logic [13:0] fire,
  input  wire logic        rx_read,
  input  wire logic        tx_write,
  // Event pulses and buffer levels.
  output logic [13:0]      evt_r,
  output logic             rx_full_r,
  output logic             tx_empty_r
);
  // Each request is registered and appears one cycle later, and a buffer level drops when software touches it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r      <= 14'h0000;
      rx_full_r  <= 1'b0;
      tx_empty_r <= 1'b1; // The transmit buffer starts out empty.
    end else begin
      evt_r      <= fire;
      rx_full_r  <= (rx_full_r | fire[5]) & ~rx_read;
      tx_empty_r <= (tx_empty_r | fire[4]) & ~tx_write;
    end
  end
endmodule

// *** testbench/peripheral_irq_flags_enables_test.sv ***
`timescale 1ns/1ps
// ==========
// Self-checking bench for the peripheral interrupt flag block.
module peripheral_irq_flags_enables_test;
  typedef struct {logic [13:0] f; logic [1:0] m; logic [7:0] a; logic [31:0] e;} pif_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] fire, evt;
  logic [1:0]  ccp_mode;
  logic        rx_read, tx_write, rx_full, tx_empty, periph_irq, irq;
  int          err_count, n_checks;
  pif_row_t    rows [13];

  // Design and peripheral model.
  pif_top pif_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_done(evt[6]), .rx_buf_full(rx_full), .tx_buf_empty(tx_empty), .ssp_done(evt[3]),
    .ccp_capture(evt[2]), .ccp_compare(evt[7]), .ccp_mode(ccp_mode), .t2_period_match(evt[1]),
    .t1_rollover(evt[0]), .reset_instr_evt(evt[8]), .wdt_timeout_evt(evt[9]), .sleep_evt(evt[10]),
    .wdt_clear_evt(evt[11]), .por_evt(evt[12]), .bor_evt(evt[13]), .periph_irq(periph_irq), .irq(irq));
  pif_periph_model pif_periph_model_i (.pclk(pclk), .presetn(presetn), .fire(fire), .rx_read(rx_read),
    .tx_write(tx_write), .evt_r(evt), .rx_full_r(rx_full), .tx_empty_r(tx_empty));

  // Free-running 40 MHz clock.
  always #12.5 pclk = ~pclk;

  // ==========
  // Shared tasks.
  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      finish_test;
    end
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h00000000, q);
    chk(nm, e, q);
  endtask

  // Raises the requested events for one cycle, then lets the results settle.
  task pulse(input logic [13:0] f);
    @(posedge pclk);
    fire <= f;
    @(posedge pclk);
    fire <= 14'h0000;
    repeat (5) @(posedge pclk);
  endtask

  // ==========
  // Main sequence.
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h00000000; fire = 14'h0000; ccp_mode = 2'h0; rx_read = 1'b0; tx_write = 1'b0;
    err_count = 0; n_checks = 0;
    rows = '{'{14'h0001, 2'h0, pif_pkg::OFF_FLAG, 32'h11}, '{14'h0002, 2'h0, pif_pkg::OFF_FLAG, 32'h13},
             '{14'h0004, 2'h1, pif_pkg::OFF_FLAG, 32'h17}, '{14'h0008, 2'h0, pif_pkg::OFF_FLAG, 32'h1f},
             '{14'h0010, 2'h0, pif_pkg::OFF_FLAG, 32'h1f}, '{14'h0020, 2'h0, pif_pkg::OFF_FLAG, 32'h3f},
             '{14'h0040, 2'h0, pif_pkg::OFF_FLAG, 32'h7f}, '{14'h0100, 2'h0, pif_pkg::OFF_RCAUSE, 32'h0c},
             '{14'h0200, 2'h0, pif_pkg::OFF_RCAUSE, 32'h04}, '{14'h0400, 2'h0, pif_pkg::OFF_RCAUSE, 32'h00},
             '{14'h0800, 2'h0, pif_pkg::OFF_RCAUSE, 32'h0c}, '{14'h1000, 2'h0, pif_pkg::OFF_RCAUSE, 32'h0c},
             '{14'h2000, 2'h0, pif_pkg::OFF_RCAUSE, 32'h0c}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Every source event with all enables off, then the reset-cause events.
    foreach (rows[i]) begin
      ccp_mode <= rows[i].m;
      pulse(rows[i].f);
      rd_chk("event_row", rows[i].a, rows[i].e);
    end
    // Clearing write leaves the serial levels; bit 7 never reads back.
    wr(pif_pkg::OFF_FLAG, 32'h00000000);
    rd_chk("flag_levels", pif_pkg::OFF_FLAG, 32'h30);
    wr(pif_pkg::OFF_ENABLE, 32'hffffffff);
    rd_chk("enable_all", pif_pkg::OFF_ENABLE, 32'h7f);
    wr(pif_pkg::OFF_FLAG, 32'h000000ff);
    rd_chk("flag_bit7", pif_pkg::OFF_FLAG, 32'h7f);
    wr(pif_pkg::OFF_FLAG, 32'h00000000);
    wr(pif_pkg::OFF_ENABLE, 32'h00000000);
    // Capture and compare do nothing in PWM mode; compare counts in compare mode.
    ccp_mode <= pif_pkg::PIF_CCP_PWM;
    pulse(14'h0084);
    rd_chk("ccp_pwm", pif_pkg::OFF_FLAG, 32'h30);
    ccp_mode <= pif_pkg::PIF_CCP_COMPARE;
    pulse(14'h0080);
    rd_chk("ccp_cmp", pif_pkg::OFF_FLAG, 32'h34);
    // Software reads the receive buffer and writes the transmit buffer.
    @(posedge pclk);
    rx_read  <= 1'b1;
    tx_write <= 1'b1;
    @(posedge pclk);
    rx_read  <= 1'b0;
    tx_write <= 1'b0;
    repeat (3) @(posedge pclk);
    rd_chk("serial_clear", pif_pkg::OFF_FLAG, 32'h04);
    // Postscaler at 1:3 needs three matches.
    wr(pif_pkg::OFF_T2CTL, 32'h00000002);
    wr(pif_pkg::OFF_FLAG, 32'h00000000);
    pulse(14'h0002);
    pulse(14'h0002);
    rd_chk("post_two", pif_pkg::OFF_FLAG, 32'h00);
    pulse(14'h0002);
    rd_chk("post_three", pif_pkg::OFF_FLAG, 32'h02);
    // A timer 1 rollover in the same cycle as a clearing write keeps its flag.
    fork
      wr(pif_pkg::OFF_FLAG, 32'h00000000);
      begin
        fire <= 14'h0001;
        @(posedge pclk);
        fire <= 14'h0000;
      end
    join
    rd_chk("t1_wins", pif_pkg::OFF_FLAG, 32'h01);
    // Request gating by group, global and priority mode.
    wr(pif_pkg::OFF_FLAG, 32'h00000000);
    wr(pif_pkg::OFF_ENABLE, 32'h00000040);
    wr(pif_pkg::OFF_IRQCTL, 32'h00000003);
    pulse(14'h0040);
    chk("pirq_on", 32'h1, {31'h0, periph_irq});
    wr(pif_pkg::OFF_IRQCTL, 32'h00000002);
    repeat (3) @(posedge pclk);
    chk("pirq_nogroup", 32'h0, {31'h0, periph_irq});
    wr(pif_pkg::OFF_RCAUSE, 32'h00000080);
    repeat (3) @(posedge pclk);
    chk("pirq_prio", 32'h1, {31'h0, periph_irq});
    rd_chk("rcause_rw", pif_pkg::OFF_RCAUSE, 32'h8c);
    // Power-on and brown-out bits are set by software and cleared by their events.
    wr(pif_pkg::OFF_RCAUSE, 32'h00000093);
    rd_chk("rcause_set", pif_pkg::OFF_RCAUSE, 32'h9f);
    pulse(14'h3000);
    rd_chk("rcause_porbor", pif_pkg::OFF_RCAUSE, 32'h9c);
    // Status and mask drive the level interrupt.
    wr(pif_pkg::OFF_STATUS, 32'h0000007f);
    wr(pif_pkg::OFF_MASK, 32'h00000040);
    pulse(14'h0040);
    rd_chk("status", pif_pkg::OFF_STATUS, 32'h40);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(pif_pkg::OFF_STATUS, 32'h00000040);
    repeat (3) @(posedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    // Unmapped address is refused.
    rd_chk("unmapped", 8'h1c, 32'h00000000);
    chk("slverr", 32'h1, {31'h0, last_err});
    // Second reset in mid-run restores the reset values.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("irq_rst", 32'h0, {30'h0, periph_irq, irq});
    presetn <= 1'b1;
    rd_chk("flag_rst", pif_pkg::OFF_FLAG, 32'h10);
    rd_chk("enable_rst", pif_pkg::OFF_ENABLE, 32'h00);
    rd_chk("rcause_rst", pif_pkg::OFF_RCAUSE, 32'h1c);
    rd_chk("t2ctl_rst", pif_pkg::OFF_T2CTL, 32'h00);
    finish_test;
  end
endmodule
